// ===== dv/lcdfs_panel_model.sv
`timescale 1ns/1ps
module lcdfs_panel_model (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        frame_sync_out,
   input wire logic [16:0] fetch_addr,
   input wire logic        fetch_valid,
   input wire logic        overlay_sel
);
   int          run;
   int          hi_run;
   int          lo_run;
   int          since_rise;
   int          gap;
   int          idle;
   int          idx;
   logic        last;
   logic [7:0]  sel_q;
   logic [16:0] addr_q [8];

   // Listens only; a long gap between words marks the first word of a frame
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         run = 0;
         hi_run = 0;
         lo_run = 0;
         since_rise = 0;
         gap = 0;
         idle = 0;
         idx = 8;
         last = 1'b1;
         sel_q = 8'h00;
      end else begin
         if (frame_sync_out !== last) begin
            if (last === 1'b1) hi_run = run;
            else lo_run = run;
            run = 1;
         end else begin
            run++;
         end
         if (frame_sync_out === 1'b1 && last === 1'b0) since_rise = 0;
         else since_rise++;
         last = frame_sync_out;
         if (fetch_valid === 1'b1) begin
            if (idle > 8) begin
               idx = 0;
               gap = since_rise;
            end
            if (idx < 8) begin
               addr_q[idx] = fetch_addr;
               sel_q[idx] = overlay_sel;
               idx++;
            end
            idle = 0;
         end else begin
            idle++;
         end
      end
   end
endmodule

// ===== dv/test_lcdfs_top.sv
`timescale 1ns/1ps
module test_lcdfs_top;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        strap = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, fso, fv, osel;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [16:0] faddr;
   int          mismatches = 0;
   int          checks_done = 0;

   always #5 clk = ~clk;

   lcdfs_top u_lcdfs_top (.CLK(clk), .RSTN(rstn), .ENDIAN_STRAP(strap),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
      .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .FRAME_SYNC_OUT(fso), .FETCH_ADDR(faddr),
      .FETCH_VALID(fv), .OVERLAY_SEL(osel));

   lcdfs_panel_model u_lcdfs_panel_model (.clk(clk), .rstn(rstn), .frame_sync_out(fso),
      .fetch_addr(faddr), .fetch_valid(fv), .overlay_sel(osel));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %08h seen %08h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", {30'h0, bresp}, {30'h0, er});
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", rdata, e);
      chk("rresp", {30'h0, rresp}, {30'h0, er});
   endtask

   task automatic chk_frame(input logic [7:0] es, input logic [16:0] ea [8]);
      chk("overlay_sel", {24'h0, u_lcdfs_panel_model.sel_q}, {24'h0, es});
      for (int i = 0; i < 8; i++) begin
         chk("fetch_addr", {15'h0, u_lcdfs_panel_model.addr_q[i]}, {15'h0, ea[i]});
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Two frames of 20 lines at 16 clocks a line, so old settings have flushed out
   task automatic frames();
      repeat (700) @(posedge clk);
   endtask

   initial begin
      logic [7:0] addrs [4] = '{8'h50, 8'h54, 8'h58, 8'h5C};
      logic       pols [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
      int         wids [4] = '{2, 2, 7, 0};
      int         g1;
      int         len;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      foreach (addrs[i]) rc(addrs[i], 32'h0, lcdfs_pkg::RESP_OKAY);
      rc(8'h60, 32'h0, lcdfs_pkg::RESP_SLVERR);
      wr(8'h60, 32'hFFFF_FFFF, 4'hF, lcdfs_pkg::RESP_SLVERR);
      $display("test registers done");
      wr(8'h20, 32'h0003_0003, 4'hF, 2'h0);
      wr(8'h30, 32'h0000_0013, 4'hF, 2'h0);
      wr(8'h34, 32'h0000_0009, 4'hF, 2'h0);
      for (int i = 0; i < 4; i++) begin
         wr(8'h3C, {8'h0, pols[i], 4'h0, 3'(wids[i]), 16'd12}, 4'hF, 2'h0);
         rc(8'h3C, {8'h0, pols[i], 4'h0, 3'(wids[i]), 16'd12}, 2'h0);
         frames();
         len = (wids[i] + 1) * 16;
         if (pols[i])
            chk("sync_active_run", 32'(u_lcdfs_panel_model.hi_run), 32'(len));
         else
            chk("sync_active_run", 32'(u_lcdfs_panel_model.lo_run), 32'(len));
      end
      g1 = u_lcdfs_panel_model.gap;
      wr(8'h3C, 32'h0080_000F, 4'hF, 2'h0);
      frames();
      chk("sync_start_shift", 32'(g1 - u_lcdfs_panel_model.gap), 32'd48);
      // Passive panel setup: active high, start at line zero
      wr(8'h3C, 32'h0080_0000, 4'hF, 2'h0);
      frames();
      chk("sync_start_zero", 32'(g1 - u_lcdfs_panel_model.gap), 32'h0000_0080);
      $display("test sync done");
      wr(8'h40, 32'h0000_0100, 4'hF, 2'h0);
      wr(8'h44, 32'h0000_0008, 4'hF, 2'h0);
      wr(8'h50, 32'h0000_2000, 4'hF, 2'h0);
      wr(8'h54, 32'h0000_0010, 4'hF, 2'h0);
      wr(8'h10, 32'h0008_0000, 4'hF, 2'h0);
      wr(8'h58, 32'h0002_0021, 4'hF, 2'h0);
      frames();
      chk("overlay_sel", {24'h0, u_lcdfs_panel_model.sel_q & 8'h66}, 32'h0);
      wr(8'h5C, 32'h0009_0000, 4'h7, 2'h0);
      frames();
      chk("overlay_sel", {24'h0, u_lcdfs_panel_model.sel_q & 8'h66}, 32'h0);
      rc(8'h58, 32'h0002_0021, 2'h0);
      wr(8'h5C, 32'h0009_0000, 4'hF, 2'h0);
      frames();
      chk_frame(8'h66, '{17'h100, 17'h2000, 17'h2001, 17'h103,
                         17'h108, 17'h2010, 17'h2011, 17'h10B});
      // Rotated: X bounds count lines, Y bounds count words
      wr(8'h10, 32'h0008_0010, 4'hF, 2'h0);
      wr(8'h58, 32'h0001_0001, 4'hF, 2'h0);
      wr(8'h5C, 32'h0002_0001, 4'hF, 2'h0);
      frames();
      chk("overlay_sel", {24'h0, u_lcdfs_panel_model.sel_q}, 32'h0000_0060);
      wr(8'h10, 32'h0, 4'hF, 2'h0);
      frames();
      chk_frame(8'h00, '{17'h100, 17'h101, 17'h102, 17'h103,
                         17'h108, 17'h109, 17'h10A, 17'h10B});
      $display("test overlay done");
      // Strap is caught only after reset, so reset again with it high
      strap <= 1'b1;
      rstn <= 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rc(8'h14, 32'h4000_0000, 2'h0);
      wr(8'h5C, 32'h0009_0000, 4'hE, 2'h0);
      rc(8'h14, 32'h4000_0000, 2'h0);
      wr(8'h5C, 32'h0009_0000, 4'h1, 2'h0);
      rc(8'h14, 32'hC000_0000, 2'h0);
      $display("test endian done");
      complete_run();
   end

   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      complete_run();
   end
endmodule

// ===== hw/lcdfs_cnt.sv
`timescale 1ns/1ps
module lcdfs_cnt (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       en,
   input  wire logic [9:0] limit,
   output wire logic [9:0] count,
   output wire logic       last
);
   typedef struct packed {
      logic [9:0] cnt;
   } lcdfs_cnt_t;

   lcdfs_cnt_t st_reg;
   lcdfs_cnt_t st_next;

   // Limit lowered below count wraps to zero on the next step
   always_comb begin
      st_next = st_reg;
      if (en) begin
         st_next.cnt = (st_reg.cnt >= limit) ? 10'h000 : st_reg.cnt + 10'h001;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign count = st_reg.cnt;
   assign last  = (st_reg.cnt >= limit);
endmodule

// ===== hw/lcdfs_pkg.sv
package lcdfs_pkg;
   // Register byte offsets
   localparam logic [7:0] A_CTRL    = 8'h10;
   localparam logic [7:0] A_STAT    = 8'h14;
   localparam logic [7:0] A_HEXT    = 8'h20;
   localparam logic [7:0] A_VTOT    = 8'h30;
   localparam logic [7:0] A_VDSP    = 8'h34;
   localparam logic [7:0] A_FSYNC   = 8'h3C;
   localparam logic [7:0] A_MSTART  = 8'h40;
   localparam logic [7:0] A_MSTRIDE = 8'h44;
   localparam logic [7:0] A_OSTART  = 8'h50;
   localparam logic [7:0] A_OSTRIDE = 8'h54;
   localparam logic [7:0] A_XB      = 8'h58;
   localparam logic [7:0] A_YB      = 8'h5C;
   // Field positions
   localparam int FLD_LO      = 0;
   localparam int FLD_HI      = 16;
   localparam int FS_POL_B    = 23;
   localparam int FS_WID_LO   = 16;
   localparam int CTRL_OVEN_B = 19;
   localparam int CTRL_BPP_LO = 0;
   localparam int CTRL_ROT_LO = 4;
   localparam int STAT_PEND_B = 31;
   localparam int STAT_END_B  = 30;
   // Reset values
   localparam logic [31:0] REG_RESET  = 32'h0000_0000;
   localparam logic        FSYNC_IDLE = 1'b1;
   // Timing
   localparam int CLK_NS       = 10;
   localparam int WORD_NS      = 40;
   localparam int TICK_CYC     = (WORD_NS + CLK_NS - 1) / CLK_NS;
   localparam int STRAP_SETTLE = 3;
   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hw/lcdfs_sync2.sv
`timescale 1ns/1ps
module lcdfs_sync2 (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic din,
   output wire logic dout
);
   typedef struct packed {
      logic s1;
      logic s2;
   } lcdfs_sync_t;

   lcdfs_sync_t st_reg;
   lcdfs_sync_t st_next;

   // First stage feeds only the second
   always_comb begin
      st_next.s1 = din;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign dout = st_reg.s2;
endmodule

// ===== hw/lcdfs_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Sync active low at 0, high at 1
// [RULE_02] Software sets polarity 1 for passive panels
// [RULE_03] Sync lasts width field plus one lines
// [RULE_04] Sync starts at the programmed line number
// [RULE_05] Software sets start zero for passive panels
// [RULE_06] Main start is a word index
// [RULE_07] Main address steps by stride each line
// [RULE_08] Software derives stride from width and depth
// [RULE_09] Larger stride gives a viewport into memory
// [RULE_10] Overlay start is a word index
// [RULE_11] Overlay ignored unless its enable is set
// [RULE_12] Overlay address steps by its stride
// [RULE_13] Bounds apply after Y write, next blanking
// [RULE_14] X end sits in bits 25-16
// [RULE_15] X start sits in bits 9-0
// [RULE_16] Unrotated X unit is one word
// [RULE_17] Rotated X unit is one line
// [RULE_18] Width limit 1024, unreachable bits ignored
// [RULE_19] Y end 25-16, start 9-0, lines; when rotated the code counts Y bounds in words
// [RULE_20] Byte lane of Y write arms update
// [RULE_21] Overlay pixels inside bounds, main outside
// [RULE_22] Shadow bounds load on deferred update
module lcdfs_top (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        ENDIAN_STRAP,
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output wire logic        AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output wire logic        WREADY,
   output wire logic [1:0]  BRESP,
   output wire logic        BVALID,
   input  wire logic        BREADY,
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output wire logic        ARREADY,
   output wire logic [31:0] RDATA,
   output wire logic [1:0]  RRESP,
   output wire logic        RVALID,
   input  wire logic        RREADY,
   output wire logic        FRAME_SYNC_OUT,
   output wire logic [16:0] FETCH_ADDR,
   output wire logic        FETCH_VALID,
   output wire logic        OVERLAY_SEL
);
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        arready;
      logic        aw_have;
      logic [7:0]  aw_addr;
      logic        w_have;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [9:0]  h_tot;
      logic [9:0]  h_dsp;
      logic [9:0]  v_tot;
      logic [9:0]  v_dsp;
      logic        ov_en;
      logic [2:0]  bpp;
      logic [1:0]  rot;
      logic        fs_pol;
      logic [2:0]  fs_wid;
      logic [9:0]  fs_start;
      logic [16:0] m_start;
      logic [9:0]  m_stride;
      logic [16:0] o_start;
      logic [9:0]  o_stride;
      logic [9:0]  xs;
      logic [9:0]  xe;
      logic [9:0]  ys;
      logic [9:0]  ye;
      logic [9:0]  axs;
      logic [9:0]  axe;
      logic [9:0]  ays;
      logic [9:0]  aye;
      logic        pend;
      logic        big_end;
      logic [1:0]  strap_cnt;
      logic [7:0]  div;
      logic [16:0] line_base;
      logic [16:0] ov_base;
      logic        fs_out;
      logic [16:0] fetch;
      logic        fvalid;
      logic        ov_sel;
   } lcdfs_st_t;

   lcdfs_st_t   st_reg;
   lcdfs_st_t   st_next;
   logic        strap_sync;
   logic [9:0]  h_cnt;
   logic [9:0]  v_cnt;
   logic        h_last;
   logic        v_last;
   logic        tick;
   logic        vnd;
   logic        disp;
   logic        rotd;
   logic [9:0]  x_mask;
   logic [9:0]  col_pos;
   logic [9:0]  row_pos;
   logic        in_x;
   logic        in_y;
   logic        ov_hit;
   logic [9:0]  ov_off;
   logic [9:0]  fs_diff;
   logic        fs_act;
   logic        wr_do;
   logic        trig;
   logic [31:0] wv;

   function automatic logic mapped(input logic [7:0] a);
      case (a)
         lcdfs_pkg::A_CTRL, lcdfs_pkg::A_STAT, lcdfs_pkg::A_HEXT,
         lcdfs_pkg::A_VTOT, lcdfs_pkg::A_VDSP, lcdfs_pkg::A_FSYNC,
         lcdfs_pkg::A_MSTART, lcdfs_pkg::A_MSTRIDE, lcdfs_pkg::A_OSTART,
         lcdfs_pkg::A_OSTRIDE, lcdfs_pkg::A_XB, lcdfs_pkg::A_YB: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] rd_word(input lcdfs_st_t s, input logic [7:0] a,
                                           input logic [9:0] hc, input logic [9:0] vc);
      logic [31:0] r;
      r = '0;
      case (a)
         lcdfs_pkg::A_CTRL: begin
            r[lcdfs_pkg::CTRL_OVEN_B]       = s.ov_en;
            r[lcdfs_pkg::CTRL_BPP_LO +: 3]  = s.bpp;
            r[lcdfs_pkg::CTRL_ROT_LO +: 2]  = s.rot;
         end
         lcdfs_pkg::A_STAT: begin
            r[lcdfs_pkg::FLD_LO +: 10]      = hc;
            r[lcdfs_pkg::FLD_HI +: 10]      = vc;
            r[lcdfs_pkg::STAT_PEND_B]       = s.pend;
            r[lcdfs_pkg::STAT_END_B]        = s.big_end;
         end
         lcdfs_pkg::A_HEXT: begin
            r[lcdfs_pkg::FLD_LO +: 10]      = s.h_tot;
            r[lcdfs_pkg::FLD_HI +: 10]      = s.h_dsp;
         end
         lcdfs_pkg::A_VTOT:    r[lcdfs_pkg::FLD_LO +: 10] = s.v_tot;
         lcdfs_pkg::A_VDSP:    r[lcdfs_pkg::FLD_LO +: 10] = s.v_dsp;
         lcdfs_pkg::A_FSYNC: begin
            r[lcdfs_pkg::FS_POL_B]          = s.fs_pol;
            r[lcdfs_pkg::FS_WID_LO +: 3]    = s.fs_wid;
            r[lcdfs_pkg::FLD_LO +: 10]      = s.fs_start;
         end
         lcdfs_pkg::A_MSTART:  r[lcdfs_pkg::FLD_LO +: 17] = s.m_start;
         lcdfs_pkg::A_MSTRIDE: r[lcdfs_pkg::FLD_LO +: 10] = s.m_stride;
         lcdfs_pkg::A_OSTART:  r[lcdfs_pkg::FLD_LO +: 17] = s.o_start;
         lcdfs_pkg::A_OSTRIDE: r[lcdfs_pkg::FLD_LO +: 10] = s.o_stride;
         lcdfs_pkg::A_XB: begin
            r[lcdfs_pkg::FLD_LO +: 10]      = s.xs;
            r[lcdfs_pkg::FLD_HI +: 10]      = s.xe;
         end
         lcdfs_pkg::A_YB: begin
            r[lcdfs_pkg::FLD_LO +: 10]      = s.ys;
            r[lcdfs_pkg::FLD_HI +: 10]      = s.ye;
         end
         default: r = '0;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            m[8*i +: 8] = d[8*i +: 8];
         end
      end
      return m;
   endfunction

   // Strap comes from a pin, so it is synchronised
   lcdfs_sync2 u_strap (
      .clk  (CLK),
      .rstn (RSTN),
      .din  (ENDIAN_STRAP),
      .dout (strap_sync)
   );

   lcdfs_cnt u_hcnt (
      .clk   (CLK),
      .rstn  (RSTN),
      .en    (tick),
      .limit (st_reg.h_tot),
      .count (h_cnt),
      .last  (h_last)
   );

   lcdfs_cnt u_vcnt (
      .clk   (CLK),
      .rstn  (RSTN),
      .en    (tick && h_last),
      .limit (st_reg.v_tot),
      .count (v_cnt),
      .last  (v_last)
   );

   assign tick    = (st_reg.div == 8'(lcdfs_pkg::TICK_CYC - 1));
   assign vnd     = (v_cnt > st_reg.v_dsp);
   assign disp    = (h_cnt <= st_reg.h_dsp) && !vnd;
   assign rotd    = st_reg.rot[0];
   assign x_mask  = 10'h3FF >> (3'h5 - st_reg.bpp);                            // RULE_18
   assign col_pos = rotd ? v_cnt : h_cnt;                                      // RULE_17
   assign row_pos = rotd ? h_cnt : v_cnt;
   assign in_x    = rotd ? (col_pos >= st_reg.axs && col_pos <= st_reg.axe)
                         : (col_pos >= (st_reg.axs & x_mask)                   // RULE_16
                            && col_pos <= (st_reg.axe & x_mask));
   assign in_y    = (row_pos >= st_reg.ays) && (row_pos <= st_reg.aye);        // RULE_19
   assign ov_hit  = st_reg.ov_en && in_x && in_y;                              // RULE_11
   assign ov_off  = rotd ? h_cnt - st_reg.ays : h_cnt - (st_reg.axs & x_mask);
   assign fs_diff = v_cnt - st_reg.fs_start;
   assign fs_act  = (v_cnt >= st_reg.fs_start)                                 // RULE_04
                    && (fs_diff <= {7'h00, st_reg.fs_wid});                    // RULE_03
   assign wr_do   = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
   assign trig    = wr_do && (st_reg.aw_addr == lcdfs_pkg::A_YB)
                    && (st_reg.big_end ? st_reg.w_strb[0] : st_reg.w_strb[3]); // RULE_20
   assign wv      = merge(rd_word(st_reg, st_reg.aw_addr, h_cnt, v_cnt),
                          st_reg.w_data, st_reg.w_strb);

   always_comb begin
      st_next = st_reg;
      // Write address and data are taken in either order
      if (AWVALID && st_reg.awready) begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = AWADDR;
      end
      if (WVALID && st_reg.wready) begin
         st_next.w_have = 1'b1;
         st_next.w_data = WDATA;
         st_next.w_strb = WSTRB;
      end
      if (BREADY && st_reg.bvalid) begin
         st_next.bvalid = 1'b0;
      end
      if (wr_do) begin
         st_next.aw_have = 1'b0;
         st_next.w_have  = 1'b0;
         st_next.bvalid  = 1'b1;
         st_next.bresp   = mapped(st_reg.aw_addr) ? lcdfs_pkg::RESP_OKAY
                                                  : lcdfs_pkg::RESP_SLVERR;
         case (st_reg.aw_addr)
            lcdfs_pkg::A_CTRL: begin
               st_next.ov_en = wv[lcdfs_pkg::CTRL_OVEN_B];
               st_next.bpp   = wv[lcdfs_pkg::CTRL_BPP_LO +: 3];
               st_next.rot   = wv[lcdfs_pkg::CTRL_ROT_LO +: 2];
            end
            lcdfs_pkg::A_HEXT: begin
               st_next.h_tot = wv[lcdfs_pkg::FLD_LO +: 10];
               st_next.h_dsp = wv[lcdfs_pkg::FLD_HI +: 10];
            end
            lcdfs_pkg::A_VTOT: st_next.v_tot = wv[lcdfs_pkg::FLD_LO +: 10];
            lcdfs_pkg::A_VDSP: st_next.v_dsp = wv[lcdfs_pkg::FLD_LO +: 10];
            lcdfs_pkg::A_FSYNC: begin
               st_next.fs_pol   = wv[lcdfs_pkg::FS_POL_B];
               st_next.fs_wid   = wv[lcdfs_pkg::FS_WID_LO +: 3];
               st_next.fs_start = wv[lcdfs_pkg::FLD_LO +: 10];
            end
            lcdfs_pkg::A_MSTART:  st_next.m_start  = wv[lcdfs_pkg::FLD_LO +: 17]; // RULE_06
            lcdfs_pkg::A_MSTRIDE: st_next.m_stride = wv[lcdfs_pkg::FLD_LO +: 10];
            lcdfs_pkg::A_OSTART:  st_next.o_start  = wv[lcdfs_pkg::FLD_LO +: 17]; // RULE_10
            lcdfs_pkg::A_OSTRIDE: st_next.o_stride = wv[lcdfs_pkg::FLD_LO +: 10];
            lcdfs_pkg::A_XB: begin
               st_next.xs = wv[lcdfs_pkg::FLD_LO +: 10];                   // RULE_15
               st_next.xe = wv[lcdfs_pkg::FLD_HI +: 10];                   // RULE_14
            end
            lcdfs_pkg::A_YB: begin
               st_next.ys = wv[lcdfs_pkg::FLD_LO +: 10];                   // RULE_19
               st_next.ye = wv[lcdfs_pkg::FLD_HI +: 10];
            end
            default: st_next.bvalid = 1'b1;
         endcase
      end
      // Read answer is registered one cycle after acceptance
      if (RREADY && st_reg.rvalid) begin
         st_next.rvalid = 1'b0;
      end
      if (ARVALID && st_reg.arready) begin
         st_next.rvalid = 1'b1;
         st_next.rdata  = rd_word(st_reg, ARADDR, h_cnt, v_cnt);
         st_next.rresp  = mapped(ARADDR) ? lcdfs_pkg::RESP_OKAY : lcdfs_pkg::RESP_SLVERR;
      end
      st_next.awready = !st_next.aw_have && !st_next.bvalid;
      st_next.wready  = !st_next.w_have && !st_next.bvalid;
      st_next.arready = !st_next.rvalid;
      // Strap caught once the synchroniser has settled
      if (st_reg.strap_cnt != 2'(lcdfs_pkg::STRAP_SETTLE)) begin
         st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
         if (st_reg.strap_cnt == 2'(lcdfs_pkg::STRAP_SETTLE - 1)) begin
            st_next.big_end = strap_sync;
         end
      end
      st_next.div = tick ? 8'h00 : st_reg.div + 8'h01;
      // Shadow load in blanking; a new trigger wins over the clear
      if (st_reg.pend && vnd) begin                                        // RULE_13
         st_next.axs  = st_reg.xs;                                         // RULE_22
         st_next.axe  = st_reg.xe;
         st_next.ays  = st_reg.ys;
         st_next.aye  = st_reg.ye;
         st_next.pend = 1'b0;
      end
      if (trig) begin
         st_next.pend = 1'b1;                                              // RULE_20
      end
      // Line bases; stride beyond width just skips memory
      if (tick && h_last) begin
         if (v_last) begin
            st_next.line_base = st_reg.m_start;                            // RULE_06
            st_next.ov_base   = st_reg.o_start;                            // RULE_10
         end else begin
            st_next.line_base = st_reg.line_base + 17'(st_reg.m_stride);   // RULE_09
            if (st_reg.ov_en && in_y) begin
               st_next.ov_base = st_reg.ov_base + 17'(st_reg.o_stride);    // RULE_12
            end
         end
      end
      st_next.fs_out = st_reg.fs_pol ? fs_act : !fs_act;                   // RULE_01
      st_next.fvalid = disp && tick;
      st_next.ov_sel = disp && ov_hit;                                     // RULE_21
      st_next.fetch  = ov_hit ? st_reg.ov_base + 17'(ov_off)
                              : st_reg.line_base + 17'(h_cnt);             // RULE_07
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_reg        <= '0;
         st_reg.fs_out <= lcdfs_pkg::FSYNC_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign AWREADY        = st_reg.awready;
   assign WREADY         = st_reg.wready;
   assign BVALID         = st_reg.bvalid;
   assign BRESP          = st_reg.bresp;
   assign ARREADY        = st_reg.arready;
   assign RVALID         = st_reg.rvalid;
   assign RDATA          = st_reg.rdata;
   assign RRESP          = st_reg.rresp;
   assign FRAME_SYNC_OUT = st_reg.fs_out;
   assign FETCH_ADDR     = st_reg.fetch;
   assign FETCH_VALID    = st_reg.fvalid;
   assign OVERLAY_SEL    = st_reg.ov_sel;

   sync_pol_a: assert property (@(posedge CLK) disable iff (!RSTN) // RULE_01
      (v_cnt == st_reg.fs_start) |=> FRAME_SYNC_OUT == $past(st_reg.fs_pol))
      else $error("frame sync polarity wrong");

   sync_width_a: assert property (@(posedge CLK) disable iff (!RSTN) // RULE_03
      (fs_act && fs_diff == {7'h00, st_reg.fs_wid} && tick && h_last && !v_last && !wr_do)
      |=> !fs_act)
      else $error("frame sync longer than width plus one");

   sync_start_a: assert property (@(posedge CLK) disable iff (!RSTN) // RULE_04
      (v_cnt == st_reg.fs_start) |-> fs_act)
      else $error("frame sync missing at start line");

   main_reload_a: assert property (@(posedge CLK) disable iff (!RSTN) // RULE_06
      (tick && h_last && v_last) |=> st_reg.line_base == $past(st_reg.m_start))
      else $error("main base not reloaded at frame end");

   main_step_a: assert property (@(posedge CLK) disable iff (!RSTN) // RULE_07
      (tick && h_last && !v_last)
      |=> st_reg.line_base == $past(st_reg.line_base) + 17'($past(st_reg.m_stride)))
      else $error("main base did not step by stride");

   ov_gate_a: assert property (@(posedge CLK) disable iff (!RSTN) // RULE_11
      !st_reg.ov_en |=> !OVERLAY_SEL)
      else $error("overlay selected while disabled");

   bound_defer_a: assert property (@(posedge CLK) disable iff (!RSTN) // RULE_13
      !$stable(st_reg.axs) |-> $past(vnd && st_reg.pend))
      else $error("bounds changed outside deferred update");

   lane_trig_a: assert property (@(posedge CLK) disable iff (!RSTN) // RULE_20
      trig |=> st_reg.pend)
      else $error("Y write on trigger lane did not arm");

   lane_skip_a: assert property (@(posedge CLK) disable iff (!RSTN) // RULE_20
      (wr_do && st_reg.aw_addr == lcdfs_pkg::A_YB && !trig && !st_reg.pend)
      |=> !st_reg.pend)
      else $error("Y write on other lane armed update");

   bad_addr_a: assert property (@(posedge CLK) disable iff (!RSTN)
      (wr_do && !mapped(st_reg.aw_addr)) |=> BVALID && BRESP == lcdfs_pkg::RESP_SLVERR)
      else $error("unmapped write not refused");
endmodule
